/* File: hdl/sfx_params.svh */
// constants for the quad serial flash sleep / continuous-read link
// assumes the includer also imports sfx_pkg for the types
`ifndef SFX_PARAMS_SVH
`define SFX_PARAMS_SVH

// ==========================================================
// opcodes and mode bytes
`define SFX_OP_SLEEP        8'hb9
`define SFX_OP_STATUS       8'h05
`define SFX_OP_SFDP         8'h5a
`define SFX_OP_QREAD        8'heb
`define SFX_MODE_KEEP       4'ha
`define SFX_MODE_EXIT       8'h00
`define SFX_MODE_RESET      32'hffffffff
`define SFX_BUSY_BIT        0

// ==========================================================
// parameter words
`define SFX_EXIT_OP         8'h00
`define SFX_WAKE_UNIT_CODE  2'h3
`define SFX_WAKE_COUNT      5'h06
`define SFX_DW14_LOW        8'hf7
`define SFX_QE_REQ          3'h5
`define SFX_XIP_ENTRY       4'hd
`define SFX_XIP_EXIT        6'h35
`define SFX_XIP_SUPPORTED   1'b1
`define SFX_QPI_ENABLE      5'h00
`define SFX_QPI_DISABLE     4'h0
`define SFX_DW14 {1'b0, `SFX_OP_SLEEP, `SFX_EXIT_OP, `SFX_WAKE_UNIT_CODE, `SFX_WAKE_COUNT, `SFX_DW14_LOW}
`define SFX_DW15 {8'hff, 1'b0, `SFX_QE_REQ, `SFX_XIP_ENTRY, `SFX_XIP_EXIT, `SFX_XIP_SUPPORTED, \
                  `SFX_QPI_ENABLE, `SFX_QPI_DISABLE}
`define SFX_SFDP_BASE       24'h000134
`define SFX_SFDP_TOP        24'h00013b

// ==========================================================
// timing
`define SFX_CORE_NS         10
`define SFX_WAKE_UNIT_NS    64000
`define SFX_WAKE_NS         ((`SFX_WAKE_COUNT + 1) * `SFX_WAKE_UNIT_NS)
`define SFX_WAKE_CYCLES     ((`SFX_WAKE_NS + `SFX_CORE_NS - 1) / `SFX_CORE_NS)
`define SFX_DUMMY_QUAD      4
`define SFX_DUMMY_SFDP      8
`define SFX_SCK_DIV         8
`define SFX_WAKE_PULSE      8

`endif

/* File: hdl/sfx_pkg.sv */
// types shared by both ends of the serial flash link
// assumes nothing beyond the params header
package sfx_pkg;

  typedef enum logic [2:0] {CMD_SLEEP, CMD_WAKE, CMD_STATUS, CMD_SFDP, CMD_QREAD, CMD_MODE_RESET} sfx_cmd_t;

  typedef enum logic [3:0] {PH_START, PH_OPC, PH_STATUS, PH_ADDR, PH_SFDP, PH_QADDR, PH_QDUMMY, PH_QDATA,
                            PH_IGNORE} sfx_phase_t;

  typedef enum logic [2:0] {HS_IDLE, HS_LEAD, HS_RUN, HS_TAIL, HS_PULSE, HS_WAIT} sfx_hstate_t;

  typedef struct packed {
    sfx_phase_t  phase;
    logic [7:0]  cnt;
    logic [31:0] sr;
    logic [23:0] addr;
    logic [7:0]  obyte;
    logic [3:0]  io_out;
    logic [3:0]  io_oe;
  } sfx_frame_t;

  typedef struct packed {
    logic xip;
    logic sleep_tgl;
    logic local_sleep;
  } sfx_link_t;

  typedef struct packed {
    logic        pending;
    logic        asleep;
    logic        waking;
    logic        quiet;
    logic        write_in_progress_flag;
    logic        cs_prev;
    logic        tgl_prev;
    logic [31:0] cnt;
  } sfx_wake_t;

  typedef struct packed {
    sfx_hstate_t state;
    logic        sck;
    logic        cs_n;
    logic [3:0]  io_out;
    logic [3:0]  io_oe;
    logic [7:0]  div;
    logic [11:0] per;
    logic [39:0] sr;
    logic [11:0] tx1;
    logic [11:0] txall;
    logic [11:0] last;
    logic [11:0] cap_lo;
    logic [11:0] cap_hi;
    logic        rx_quad;
    logic [7:0]  rx_sh;
    logic [3:0]  rx_bits;
    logic [7:0]  rdata;
    logic        rvalid;
    logic        xip;
    logic        ready;
    logic [31:0] wcnt;
  } sfx_host_t;

endpackage

/* File: hdl/sfx_if.sv */
// quad serial link between controller and flash
// assumes a pull-up on every data line
`timescale 1ns/100ps
interface sfx_if;
  logic       sck;
  logic       cs_n;
  logic [3:0] host_io_out;
  logic [3:0] host_io_oe;
  logic [3:0] dev_io_out;
  logic [3:0] dev_io_oe;
  logic [3:0] io;

  // wire level: driven value, else pulled high
  assign io = (dev_io_oe & dev_io_out) | (host_io_oe & host_io_out) | ~(dev_io_oe | host_io_oe);

  modport ctrl  (output sck, cs_n, host_io_out, host_io_oe, input io);
  modport flash (input sck, cs_n, io, output dev_io_out, dev_io_oe);
endinterface

/* File: hdl/sfx_sync.sv */
// two-flop synchroniser for levels
// assumes the source is a flop in another domain
`timescale 1ns/100ps
module sfx_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rstn,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta;

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      meta <= '0;
      o_q  <= '0;
    end
    else
    begin
      meta <= i_d;
      o_q  <= meta;
    end
  end
endmodule // sfx_sync

/* File: hdl/sfx_flash_end.sv */
// flash end: deep sleep, wake delay, status, parameter read, continuous quad read
// assumes the controller stops sck while cs_n is high
`timescale 1ns/100ps
`include "sfx_params.svh"
module sfx_flash_end import sfx_pkg::*; #(
  parameter int WAKE_CYCLES = `SFX_WAKE_CYCLES,
  parameter int DUMMY       = `SFX_DUMMY_QUAD
) (
  input  wire logic i_core_clk,
  input  wire logic i_rstn,
  input  wire logic i_write_in_progress_flag,
  output logic      o_deep_sleep_state,
  output logic      o_waking,
  output logic      o_xip_active,
  sfx_if.flash      link
);

  if (WAKE_CYCLES < 1 || DUMMY < 1 || DUMMY > 255)
  begin : g_bad
    $error("sfx_flash_end: bad parameter");
  end

  // ==========================================================
  // parameter word lookup
  function automatic logic [7:0] sfdp_byte(input logic [23:0] a);
    logic [63:0] words;
    logic [23:0] off;
    words = {`SFX_DW15, `SFX_DW14};
    off   = a - `SFX_SFDP_BASE;
    if (a >= `SFX_SFDP_BASE && a <= `SFX_SFDP_TOP)
      sfdp_byte = words[{off[2:0], 3'h0} +: 8];
    else
      sfdp_byte = 8'h00;
  endfunction

  sfx_wake_t  wk;
  sfx_wake_t  next_wk;
  sfx_link_t  lk;
  sfx_link_t  next_lk;
  sfx_frame_t fr;
  sfx_frame_t next_fr;
  logic [1:0] core_in;
  logic [2:0] link_in;
  logic       frame_rstn;

  assign frame_rstn = i_rstn & ~link.cs_n;

  // ==========================================================
  // crossings
  sfx_sync #(.W(2)) u_core_sync (
    .i_clk  (i_core_clk),
    .i_rstn (i_rstn),
    .i_d    ({link.cs_n, lk.sleep_tgl}),
    .o_q    (core_in)
  );

  // echo of the sleep toggle tells the link side the core has taken it
  sfx_sync #(.W(3)) u_link_sync (
    .i_clk  (link.sck),
    .i_rstn (i_rstn),
    .i_d    ({wk.tgl_prev, wk.quiet, wk.write_in_progress_flag}),
    .o_q    (link_in)
  );

  // ==========================================================
  // core side: sleep entry and wake timer
  always_comb
  begin
    next_wk          = wk;
    next_wk.cs_prev  = core_in[1];
    next_wk.tgl_prev = core_in[0];
    next_wk.write_in_progress_flag      = i_write_in_progress_flag;
    if (core_in[0] != wk.tgl_prev)
      next_wk.pending = 1'b1;
    if (wk.pending && core_in[1])
    begin
      next_wk.pending = 1'b0;
      next_wk.asleep  = 1'b1;
    end
    if (wk.asleep && wk.cs_prev && !core_in[1])
    begin
      next_wk.asleep = 1'b0;
      next_wk.waking = 1'b1;
      next_wk.cnt    = '0;
    end
    if (wk.waking)
    begin
      next_wk.cnt = wk.cnt + 32'h1;
      if (wk.cnt == 32'(WAKE_CYCLES - 1))
        next_wk.waking = 1'b0;
    end
    next_wk.quiet = next_wk.pending | next_wk.asleep | next_wk.waking;
  end

  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      wk <= '0;
    else
      wk <= next_wk;
  end

  // ==========================================================
  // link side: one step per rising sck edge
  always_comb
  begin
    sfx_phase_t  ph;
    logic [31:0] full;
    logic [7:0]  nb;
    logic [7:0]  status;
    logic [23:0] naddr;
    logic        quiet;
    ph           = fr.phase;
    full         = '0;
    nb           = '0;
    status       = 8'h00;
    status[`SFX_BUSY_BIT] = link_in[0];
    naddr        = fr.addr + 24'h1;
    quiet        = link_in[1] | (lk.local_sleep & (link_in[2] != lk.sleep_tgl));
    next_fr      = fr;
    next_lk      = lk;
    if (ph == PH_START)
      ph = lk.xip ? PH_QADDR : PH_OPC;
    next_fr.phase = ph;
    next_fr.cnt   = fr.cnt + 8'h1;
    next_fr.sr    = {fr.sr[30:0], link.io[0]};
    case (ph)
      PH_OPC:
      begin
        if (fr.cnt == 8'h07)
        begin
          next_fr.cnt   = 8'h00;
          next_fr.phase = PH_IGNORE;
          if (link_in[2] == lk.sleep_tgl)
            next_lk.local_sleep = 1'b0;
          if (!quiet)
          begin
            case (next_fr.sr[7:0])
              `SFX_OP_SLEEP:
              begin
                next_lk.sleep_tgl   = ~lk.sleep_tgl;
                next_lk.local_sleep = 1'b1;
                next_lk.xip         = 1'b0;
              end
              `SFX_OP_STATUS:
              begin
                next_fr.phase  = PH_STATUS;
                next_fr.obyte  = {status[6:0], status[7]};
                next_fr.io_out = {2'b00, status[7], 1'b0};
                next_fr.io_oe  = 4'h2;
              end
              `SFX_OP_SFDP:
                next_fr.phase = PH_ADDR;
              `SFX_OP_QREAD:
                next_fr.phase = PH_QADDR;
              default:
                next_fr.phase = PH_IGNORE;
            endcase
          end
        end
      end
      PH_STATUS:
      begin
        next_fr.cnt       = fr.cnt;
        next_fr.io_out[1] = fr.obyte[7];
        next_fr.obyte     = {fr.obyte[6:0], fr.obyte[7]};
      end
      PH_ADDR:
      begin
        if (fr.cnt == 8'd23)
          next_fr.addr = next_fr.sr[23:0];
        if (fr.cnt == 8'(23 + `SFX_DUMMY_SFDP))
        begin
          nb             = sfdp_byte(fr.addr);
          next_fr.io_out = {2'b00, nb[7], 1'b0};
          next_fr.io_oe  = 4'h2;
          next_fr.obyte  = {nb[6:0], 1'b0};
          next_fr.cnt    = 8'h01;
          next_fr.phase  = PH_SFDP;
        end
      end
      PH_SFDP:
      begin
        if (fr.cnt == 8'h08)
        begin
          nb             = sfdp_byte(naddr);
          next_fr.addr   = naddr;
          next_fr.io_out = {2'b00, nb[7], 1'b0};
          next_fr.obyte  = {nb[6:0], 1'b0};
          next_fr.cnt    = 8'h01;
        end
        else
        begin
          next_fr.io_out = {2'b00, fr.obyte[7], 1'b0};
          next_fr.obyte  = {fr.obyte[6:0], 1'b0};
        end
      end
      PH_QADDR:
      begin
        next_fr.sr = {fr.sr[27:0], link.io};
        if (fr.cnt == 8'h07)
        begin
          full          = next_fr.sr;
          next_fr.addr  = full[31:8];
          next_fr.cnt   = 8'h00;
          next_fr.phase = PH_QDUMMY;
          if (full == `SFX_MODE_RESET)
          begin
            next_lk.xip   = 1'b0;
            next_fr.phase = PH_IGNORE;
          end
          else if (full[7:0] == `SFX_MODE_EXIT)
            next_lk.xip = 1'b0;
          else
            next_lk.xip = (full[7:4] == `SFX_MODE_KEEP);
        end
      end
      PH_QDUMMY:
      begin
        if (fr.cnt == 8'(DUMMY - 1))
        begin
          nb             = fr.addr[7:0];
          next_fr.io_out = nb[7:4];
          next_fr.io_oe  = 4'hf;
          next_fr.obyte  = nb;
          next_fr.cnt    = 8'h01;
          next_fr.phase  = PH_QDATA;
        end
      end
      PH_QDATA:
      begin
        if (fr.cnt == 8'h02)
        begin
          nb             = naddr[7:0];
          next_fr.addr   = naddr;
          next_fr.io_out = nb[7:4];
          next_fr.obyte  = nb;
          next_fr.cnt    = 8'h01;
        end
        else
        begin
          next_fr.io_out = fr.obyte[3:0];
          next_fr.cnt    = 8'h02;
        end
      end
      default:
        next_fr.cnt = fr.cnt;
    endcase
  end

  always_ff @(posedge link.sck or negedge i_rstn)
  begin
    if (!i_rstn)
      lk <= '0;
    else
      lk <= next_lk;
  end

  always_ff @(posedge link.sck or negedge frame_rstn)
  begin
    if (!frame_rstn)
      fr <= '{phase: PH_START, default: '0};
    else
      fr <= next_fr;
  end

  // ==========================================================
  // outputs
  assign link.dev_io_out   = fr.io_out;
  assign link.dev_io_oe    = fr.io_oe;
  assign o_deep_sleep_state = wk.asleep;
  assign o_waking           = wk.waking;
  assign o_xip_active       = lk.xip;

endmodule // sfx_flash_end

/* File: hdl/sfx_ctrl_end.sv */
// controller end: builds frames, divides core clock into sck, collects read bytes
// assumes the flash end on the far side of sfx_if
`timescale 1ns/100ps
`include "sfx_params.svh"
module sfx_ctrl_end import sfx_pkg::*; #(
  parameter int DIV         = `SFX_SCK_DIV,
  parameter int DUMMY       = `SFX_DUMMY_QUAD,
  parameter int WAKE_CYCLES = `SFX_WAKE_CYCLES,
  parameter int PULSE       = `SFX_WAKE_PULSE
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_cmd_valid,
  input  wire sfx_cmd_t    i_cmd,
  input  wire logic [23:0] i_addr,
  input  wire logic [7:0]  i_mode,
  input  wire logic [7:0]  i_len,
  output logic             o_cmd_ready,
  output logic [7:0]       o_rdata,
  output logic             o_rdata_valid,
  output logic             o_xip,
  sfx_if.ctrl              link
);

  if (DIV < 6 || DIV > 254 || (DIV % 2) != 0 || DUMMY < 1 || DUMMY > 15 || WAKE_CYCLES < 1 || PULSE < 4)
  begin : g_bad
    $error("sfx_ctrl_end: bad parameter");
  end

  localparam logic [7:0] HALF = 8'(DIV / 2);

  sfx_host_t  h;
  sfx_host_t  next_h;
  logic [3:0] ios;

  sfx_sync #(.W(4)) u_io_sync (
    .i_clk  (i_core_clk),
    .i_rstn (i_rstn),
    .i_d    (link.io),
    .o_q    (ios)
  );

  // ==========================================================
  // frame sequencer
  always_comb
  begin
    logic [11:0] tx4;
    logic [11:0] dmy;
    logic [11:0] rxc;
    logic [11:0] nper;
    tx4           = '0;
    dmy           = '0;
    rxc           = '0;
    nper          = h.per + 12'h1;
    next_h        = h;
    next_h.rvalid = 1'b0;
    case (h.state)
      HS_IDLE:
      begin
        if (i_cmd_valid)
        begin
          next_h.tx1     = '0;
          next_h.rx_quad = 1'b0;
          next_h.sr      = '0;
          case (i_cmd)
            CMD_SLEEP:
            begin
              next_h.sr  = {`SFX_OP_SLEEP, 32'h0};
              next_h.tx1 = 12'd8;
              next_h.xip = 1'b0;
            end
            CMD_STATUS:
            begin
              next_h.sr  = {`SFX_OP_STATUS, 32'h0};
              next_h.tx1 = 12'd8;
              rxc        = {1'b0, i_len, 3'h0};
            end
            CMD_SFDP:
            begin
              next_h.sr  = {`SFX_OP_SFDP, i_addr, 8'h0};
              next_h.tx1 = 12'd32;
              dmy        = 12'(`SFX_DUMMY_SFDP);
              rxc        = {1'b0, i_len, 3'h0};
            end
            CMD_QREAD:
            begin
              if (h.xip)
                next_h.sr = {i_addr, i_mode, 8'h0};
              else
              begin
                next_h.sr  = {`SFX_OP_QREAD, i_addr, i_mode};
                next_h.tx1 = 12'd8;
              end
              tx4            = 12'd8;
              dmy            = 12'(DUMMY);
              rxc            = {3'h0, i_len, 1'b0};
              next_h.rx_quad = 1'b1;
              next_h.xip     = (i_mode[7:4] == `SFX_MODE_KEEP) && (i_mode != `SFX_MODE_EXIT);
            end
            CMD_MODE_RESET:
            begin
              next_h.sr  = '1;
              tx4        = 12'd8;
              next_h.xip = 1'b0;
            end
            default:
              next_h.sr = '0;
          endcase
          next_h.txall   = next_h.tx1 + tx4;
          next_h.cap_lo  = next_h.txall + dmy - 12'h1;
          next_h.cap_hi  = next_h.cap_lo + rxc - 12'h1;
          next_h.last    = (rxc == 12'h0) ? next_h.cap_lo : next_h.cap_hi;
          next_h.per     = '0;
          next_h.div     = '0;
          next_h.rx_bits = '0;
          next_h.wcnt    = '0;
          next_h.cs_n    = 1'b0;
          next_h.state   = (i_cmd == CMD_WAKE) ? HS_PULSE : HS_LEAD;
          if (i_cmd == CMD_WAKE)
            next_h.io_oe = 4'h0;
          else if (next_h.tx1 != 12'h0)
          begin
            next_h.io_out = {3'h0, next_h.sr[39]};
            next_h.io_oe  = 4'h1;
          end
          else
          begin
            next_h.io_out = next_h.sr[39:36];
            next_h.io_oe  = 4'hf;
          end
        end
      end
      HS_LEAD:
      begin
        next_h.div = h.div + 8'h1;
        if (h.div == HALF - 8'h1)
        begin
          next_h.div   = '0;
          next_h.sck   = 1'b1;
          next_h.state = HS_RUN;
        end
      end
      HS_RUN:
      begin
        next_h.div = h.div + 8'h1;
        if (h.div == HALF - 8'h1)
        begin
          next_h.sck = 1'b0;
          if (nper < h.txall)
          begin
            next_h.sr = (h.per < h.tx1) ? {h.sr[38:0], 1'b0} : {h.sr[35:0], 4'h0};
            if (nper < h.tx1)
            begin
              next_h.io_out = {3'h0, next_h.sr[39]};
              next_h.io_oe  = 4'h1;
            end
            else
            begin
              next_h.io_out = next_h.sr[39:36];
              next_h.io_oe  = 4'hf;
            end
          end
          else
            next_h.io_oe = 4'h0;
        end
        if (h.div == 8'(DIV - 1))
        begin
          if (h.per >= h.cap_lo && h.per <= h.cap_hi)
          begin
            next_h.rx_sh   = h.rx_quad ? {h.rx_sh[3:0], ios} : {h.rx_sh[6:0], ios[1]};
            next_h.rx_bits = h.rx_bits + (h.rx_quad ? 4'h4 : 4'h1);
            if (next_h.rx_bits == 4'h8)
            begin
              next_h.rdata   = next_h.rx_sh;
              next_h.rvalid  = 1'b1;
              next_h.rx_bits = '0;
            end
          end
          next_h.div = '0;
          if (h.per == h.last)
            next_h.state = HS_TAIL;
          else
          begin
            next_h.per = nper;
            next_h.sck = 1'b1;
          end
        end
      end
      HS_TAIL:
      begin
        next_h.div = h.div + 8'h1;
        if (h.div == HALF - 8'h1)
        begin
          next_h.cs_n  = 1'b1;
          next_h.io_oe = 4'h0;
        end
        if (h.div == 8'(DIV - 1))
          next_h.state = HS_IDLE;
      end
      HS_PULSE:
      begin
        next_h.wcnt = h.wcnt + 32'h1;
        if (h.wcnt == 32'(PULSE - 1))
        begin
          next_h.cs_n  = 1'b1;
          next_h.wcnt  = '0;
          next_h.state = HS_WAIT;
        end
      end
      HS_WAIT:
      begin
        next_h.wcnt = h.wcnt + 32'h1;
        if (h.wcnt == 32'(WAKE_CYCLES - 1))
          next_h.state = HS_IDLE;
      end
      default:
        next_h.state = HS_IDLE;
    endcase
    next_h.ready = (next_h.state == HS_IDLE) && !(h.state == HS_IDLE && i_cmd_valid);
  end

  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      h <= '{state: HS_IDLE, cs_n: 1'b1, ready: 1'b1, default: '0};
    else
      h <= next_h;
  end

  // ==========================================================
  // outputs
  assign link.sck         = h.sck;
  assign link.cs_n        = h.cs_n;
  assign link.host_io_out = h.io_out;
  assign link.host_io_oe  = h.io_oe;
  assign o_cmd_ready      = h.ready;
  assign o_rdata          = h.rdata;
  assign o_rdata_valid    = h.rvalid;
  assign o_xip            = h.xip;

endmodule // sfx_ctrl_end

/* File: bench/sfx_link_checker.sv */
// assertions on the quad link between controller and flash ends
// assumes sck is made from the core clock, so one domain serves both
`timescale 1ns/100ps
module sfx_link_checker (
  input wire logic       i_core_clk,
  input wire logic       i_rstn,
  input wire logic       sck,
  input wire logic       cs_n,
  input wire logic [3:0] host_io_out,
  input wire logic [3:0] host_io_oe,
  input wire logic [3:0] dev_io_out,
  input wire logic [3:0] dev_io_oe,
  input wire logic [3:0] io
);
  // ==========================================================
  // link timing
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);

  sequence s_sck_high;
    sck [*4] ##1 !sck;
  endsequence

  sequence s_lead;
    (!cs_n && !sck) [*4];
  endsequence

  a_cs_lead_quiet: assert property ($fell(cs_n) |-> s_lead) else $error("sck early in frame");
  a_sck_high_len: assert property ($rose(sck) |-> s_sck_high) else $error("sck high phase wrong");
  a_sck_idle_off: assert property (cs_n |-> !sck) else $error("sck runs outside frame");
  a_cs_rise_low: assert property ($rose(cs_n) |-> !sck && !$past(sck)) else $error("frame cut mid clock");
  a_dev_quiet_idle: assert property (cs_n |-> dev_io_oe == 4'h0) else $error("flash drives when idle");
  a_no_line_fight: assert property ((dev_io_oe & host_io_oe) == 4'h0) else $error("both ends drive");
  a_dev_oe_shape: assert property (dev_io_oe inside {4'h0, 4'h2, 4'hf}) else $error("odd flash enable");
  a_dev_on_rise: assert property (!cs_n && $changed(dev_io_out) |-> $rose(sck)) else $error("flash data off edge");
  a_idle_lines_high: assert property (cs_n |-> io == 4'hf) else $error("lines not high when idle");
  a_serial_line0: assert property (host_io_oe == 4'h1 |-> host_io_out[3:1] == 3'h0) else $error("serial off line 0");
endmodule // sfx_link_checker

/* File: bench/sfdp_power_down_and_xip_mode_tb_top.sv */
// bench: controller and flash ends face to face, model in queues
// assumes sfx_pkg, sfx_if and both ends compiled first
`timescale 1ns/100ps
module sfdp_power_down_and_xip_mode_tb_top import sfx_pkg::*;;
  localparam int WAKE = 200;
  localparam logic [31:0] DW14 = {1'b0, 8'hb9, 8'h00, 2'b11, 5'b00110, 8'hf7};
  localparam logic [31:0] DW15 = {8'hff, 1'b0, 3'b101, 4'b1101, 6'b110101, 1'b1, 5'h0, 4'h0};
  localparam logic [7:0] XM [8] = '{8'ha5, 8'ha0, 8'h00, 8'ha7, 8'hff, 8'h5a, 8'ha3, 8'hff};
  logic        i_core_clk = 0, i_rstn = 1, valid = 0, write_in_progress_flag = 0, m_xip = 0, m_sleep = 0;
  sfx_cmd_t    cmd = CMD_STATUS;
  logic [23:0] addr = '0;
  logic [7:0]  mode = '0, len = '0, rdata;
  logic        ready, rvalid, xip, sleep_st, waking, xip_act;
  logic [7:0]  got[$];
  logic [31:0] lf = 32'hfbe2;
  int          n_fail = 0, check_count = 0, wake_n = 0, k;

  sfx_if lnk();
  sfx_ctrl_end #(.WAKE_CYCLES(WAKE)) i_sfx_ctrl_end (.i_core_clk(i_core_clk), .i_rstn(i_rstn),
    .i_cmd_valid(valid), .i_cmd(cmd), .i_addr(addr), .i_mode(mode), .i_len(len), .o_cmd_ready(ready),
    .o_rdata(rdata), .o_rdata_valid(rvalid), .o_xip(xip), .link(lnk));
  sfx_flash_end #(.WAKE_CYCLES(WAKE)) i_sfx_flash_end (.i_core_clk(i_core_clk), .i_rstn(i_rstn),
    .i_write_in_progress_flag(write_in_progress_flag), .o_deep_sleep_state(sleep_st), .o_waking(waking),
    .o_xip_active(xip_act), .link(lnk));
  sfx_link_checker i_sfx_link_checker (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .sck(lnk.sck),
    .cs_n(lnk.cs_n), .host_io_out(lnk.host_io_out), .host_io_oe(lnk.host_io_oe),
    .dev_io_out(lnk.dev_io_out), .dev_io_oe(lnk.dev_io_oe), .io(lnk.io));

  // ==========================================================
  // clock, capture, helpers
  always #5 i_core_clk = ~i_core_clk;

  always @(posedge i_core_clk)
  begin
    if (rvalid === 1'b1) got.push_back(rdata);
    if (waking === 1'b1) wake_n++;
  end

  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one command, then model update and compare of every result
  task automatic run(input sfx_cmd_t c, input logic [23:0] a, input logic [7:0] m, input logic [7:0] n);
    logic [63:0] t;
    logic [23:0] p;
    logic        s;
    t = {DW15, DW14};
    s = m_sleep;
    got.delete();
    cmd = c; addr = a; mode = m; len = n; valid = 1'b1;
    @(posedge i_core_clk);
    #1 valid = 1'b0;
    k = 0;
    while (ready !== 1'b1 && k < 9000)
    begin
      @(posedge i_core_clk);
      #1 k++;
    end
    repeat (8) @(posedge i_core_clk);
    #1;
    if (c == CMD_QREAD) m_xip = (m[7:4] == 4'ha);
    if (c == CMD_MODE_RESET || c == CMD_SLEEP) m_xip = 1'b0;
    m_sleep = (c == CMD_SLEEP);
    chk(k < 9000, 1);
    chk(got.size(), (c == CMD_STATUS || c == CMD_SFDP || c == CMD_QREAD) ? n : 0);
    foreach (got[i])
    begin
      p = a + i[23:0];
      chk(got[i], c == CMD_STATUS ? (s ? 8'hff : {7'h0, write_in_progress_flag}) : c == CMD_QREAD ? p[7:0] :
          (p >= 24'h134 && p <= 24'h13b) ? t[(p - 24'h134) * 8 +: 8] : 8'h00);
    end
    chk(xip, m_xip);
    chk(xip_act, m_xip);
    chk(sleep_st, m_sleep);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    #200000;
    n_fail++;
    end_of_test();
  end

  // ==========================================================
  // tests
  initial
  begin
    #1 i_rstn = 1'b0;
    repeat (5) @(posedge i_core_clk);
    #1 i_rstn = 1'b1;
    @(posedge i_core_clk);
    #1;
    run(CMD_SFDP, 24'h000130, 8'h00, 8'h10);
    lf = nxt(lf);
    run(CMD_SFDP, {20'h00013, lf[3:0]}, 8'h00, 8'h04);
    $display("test parameter words done");
    for (int j = 0; j < 4; j++)
    begin
      lf = nxt(lf);
      write_in_progress_flag = lf[0];
      run(CMD_STATUS, 24'h0, 8'h00, {6'h0, lf[2:1]} + 8'h01);
    end
    $display("test status done");
    foreach (XM[j])
    begin
      lf = nxt(lf);
      if (XM[j] == 8'hff)
        run(CMD_MODE_RESET, 24'h0, 8'h00, 8'h00);
      else
        run(CMD_QREAD, lf[23:0], XM[j], {5'h0, lf[26:24]} + 8'h01);
    end
    $display("test continuous read done");
    run(CMD_SLEEP, 24'h0, 8'h00, 8'h00);
    wake_n = 0;
    run(CMD_STATUS, 24'h0, 8'h00, 8'h01);
    run(CMD_WAKE, 24'h0, 8'h00, 8'h00);
    chk(wake_n >= WAKE && wake_n <= WAKE + 2, 1);
    write_in_progress_flag = 1'b0;
    run(CMD_STATUS, 24'h0, 8'h00, 8'h02);
    $display("test sleep and wake done");
    end_of_test();
  end
endmodule // sfdp_power_down_and_xip_mode_tb_top
